// *** pcg_defs.vh ***
// Behaviour
// - a gating bit at 0 passes clocks, at 1 stops them; all bits reset to 0.
// - one gating bit stops or passes both high and low speed clocks together.
// - bits of peripherals absent in a variant ignore writes and read zero.
// - registers sit at 0xF070, 0xF072, 0xF074; low byte even, high byte odd.
// - registers accept byte and word access and reset to all zero.
// - first register bits 7..0 gate general timers 7..0; 15..8 unused.
// - second register bits 7..0 gate functional timers by bit index.
// - second register bit 12 gates i2c unit 0, bits 9,8 i2c masters 1,0.
// - third register bits 5..0 gate serial units 5..0.
// - third register bits 15,14,13,11 gate dma, buzzer, mul/div, crc.
// - reset-hold bit at 1 holds the peripheral in reset, 0 releases; reset 0.
`ifndef PCG_DEFS_VH
`define PCG_DEFS_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define PCG_ADDR_GATE_TIMERS   16'hF070
`define PCG_ADDR_GATE_FTIM_I2C 16'hF072
`define PCG_ADDR_GATE_SER_MISC 16'hF074
`define PCG_ADDR_RST_TIMERS    16'hF078
`define PCG_ADDR_RST_FTIM_I2C  16'hF07A
`define PCG_ADDR_RST_SER_MISC  16'hF07C

// ****************************************
// writable bit masks and reset value
// ****************************************
`define PCG_MASK_TIMERS   16'h00FF
`define PCG_MASK_FTIM_I2C 16'h13FF
`define PCG_MASK_SER_MISC 16'hE83F
`define PCG_RESET_VALUE   16'h0000

// ****************************************
// field positions
// ****************************************
`define PCG_BIT_I2C_UNIT_0   12
`define PCG_BIT_I2C_MASTER_1 9
`define PCG_BIT_I2C_MASTER_0 8
`define PCG_BIT_DMA_ENGINE   15
`define PCG_BIT_BUZZER       14
`define PCG_BIT_MUL_DIV_UNIT 13
`define PCG_BIT_CRC_UNIT     11

`endif

// *** pcg_ctl_reg.v ***
`timescale 1ns/10ps
`include "pcg_defs.vh"

// one 16-bit control register with byte lane writes and a fixed writable mask
module pcg_ctl_reg #(
    parameter [15:0] WRITE_MASK = 16'hFFFF
) (
    // clock and reset
    input  wire        clk,
    input  wire        srst,
    // write port
    input  wire        wrEn,
    input  wire [1:0]  byteEn,
    input  wire [15:0] wrData,
    // state
    output wire [15:0] value
);

    reg  [15:0] value_reg;
    reg  [15:0] value_next;

    // ****************************************
    // lane merge
    // ****************************************
    // only masked bits ever take a one, so absent bits stay zero
    always @*
    begin
        value_next = value_reg;
        if (wrEn)
        begin
            if (byteEn[0])
                value_next[7:0] = wrData[7:0];
            if (byteEn[1])
                value_next[15:8] = wrData[15:8];
        end
        value_next = value_next & WRITE_MASK;
    end

    // register, zero after reset
    always @(posedge clk)
    begin
        if (srst)
            value_reg <= `PCG_RESET_VALUE;
        else
            value_reg <= value_next;
    end

    assign value = value_reg;

endmodule // pcg_ctl_reg

// *** pcg_gating_bank.v ***
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "pcg_defs.vh"

// peripheral clock gating bank with companion reset-hold registers
module pcg_gating_bank #(
    // variant masks: clear a bit for a peripheral absent from the product
    parameter [15:0] PRESENT_TIMERS   = 16'hFFFF,
    parameter [15:0] PRESENT_FTIM_I2C = 16'hFFFF,
    parameter [15:0] PRESENT_SER_MISC = 16'hFFFF
) (
    // clock and reset
    input  wire        clk,
    input  wire        srst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // high speed clock enables, one per peripheral
    output wire [7:0]  hsEnGenTimer,
    output wire [7:0]  hsEnFuncTimer,
    output wire        hsEnI2cUnit0,
    output wire [1:0]  hsEnI2cMaster,
    output wire [5:0]  hsEnSerialUnit,
    output wire        hsEnDmaEngine,
    output wire        hsEnBuzzer,
    output wire        hsEnMulDivUnit,
    output wire        hsEnCrcUnit,
    // low speed clock enables, one per peripheral
    output wire [7:0]  lsEnGenTimer,
    output wire [7:0]  lsEnFuncTimer,
    output wire        lsEnI2cUnit0,
    output wire [1:0]  lsEnI2cMaster,
    output wire [5:0]  lsEnSerialUnit,
    output wire        lsEnDmaEngine,
    output wire        lsEnBuzzer,
    output wire        lsEnMulDivUnit,
    output wire        lsEnCrcUnit,
    // peripheral reset holds, active high
    output wire [15:0] rstHoldTimers,
    output wire [15:0] rstHoldFtimI2c,
    output wire [15:0] rstHoldSerMisc
);

    localparam NUM_REGS = 6;

    // ****************************************
    // decode
    // ****************************************
    // the word address selects a register; bit 0 of paddr is dropped from it
    // so both even and odd byte addresses reach the same register
    wire        wrAccess = psel & penable & pwrite;
    wire [15:0] wordAddr = {paddr[15:1], 1'b0};
    reg  [NUM_REGS-1:0] regHit;
    wire        anyHit   = |regHit;

    always @*
    begin
        regHit    = 6'h00;
        regHit[0] = (wordAddr == `PCG_ADDR_GATE_TIMERS);
        regHit[1] = (wordAddr == `PCG_ADDR_GATE_FTIM_I2C);
        regHit[2] = (wordAddr == `PCG_ADDR_GATE_SER_MISC);
        regHit[3] = (wordAddr == `PCG_ADDR_RST_TIMERS);
        regHit[4] = (wordAddr == `PCG_ADDR_RST_FTIM_I2C);
        regHit[5] = (wordAddr == `PCG_ADDR_RST_SER_MISC);
    end

    // ****************************************
    // byte lanes
    // ****************************************
    // a 16-bit register occupies the low half of the apb word; an odd byte
    // address writes the high byte alone, taking lane 0 unless pstrb[1] is set, so 8-bit cpu moves work
    reg  [1:0]  laneEn;
    reg  [15:0] laneData;

    always @*
    begin
        if (paddr[0])
        begin
            laneEn   = {pstrb[0] | pstrb[1], 1'b0};
            laneData = {pstrb[1] ? pwdata[15:8] : pwdata[7:0], 8'h00};
        end
        else
        begin
            laneEn   = pstrb[1:0];
            laneData = pwdata[15:0];
        end
    end

    // ****************************************
    // register array
    // ****************************************
    wire [16*NUM_REGS-1:0] regFlat;
    // constant so that each slice can set a parameter of the register below
    localparam [16*NUM_REGS-1:0] MASK_FLAT = {
        `PCG_MASK_SER_MISC & PRESENT_SER_MISC,
        `PCG_MASK_FTIM_I2C & PRESENT_FTIM_I2C,
        `PCG_MASK_TIMERS   & PRESENT_TIMERS,
        `PCG_MASK_SER_MISC & PRESENT_SER_MISC,
        `PCG_MASK_FTIM_I2C & PRESENT_FTIM_I2C,
        `PCG_MASK_TIMERS   & PRESENT_TIMERS
    };

    // absent peripherals and unused positions drop out through the mask
    genvar r;
    generate
        for (r = 0; r < NUM_REGS; r = r + 1)
        begin : gRegs
            pcg_ctl_reg #(
                .WRITE_MASK (MASK_FLAT[16*r+15:16*r])
            ) uReg (
                .clk    (clk),
                .srst   (srst),
                .wrEn   (wrAccess & regHit[r]),
                .byteEn (laneEn),
                .wrData (laneData),
                .value  (regFlat[16*r+15:16*r])
            );
        end
    endgenerate

    wire [15:0] gateTimers  = regFlat[15:0];
    wire [15:0] gateFtimI2c = regFlat[31:16];
    wire [15:0] gateSerMisc = regFlat[47:32];

    // ****************************************
    // read path
    // ****************************************
    // read data is registered in the setup cycle; odd byte address mirrors
    // the high byte onto lane 0; unmapped addresses read zero
    reg [15:0] rdSel;
    integer    k;

    always @*
    begin
        rdSel = 16'h0000;
        for (k = 0; k < NUM_REGS; k = k + 1)
            if (regHit[k])
                rdSel = regFlat[16*k +: 16];
    end

    always @(posedge clk)
    begin
        if (srst)
            prdata <= 32'h00000000;
        else if (psel & ~penable)
            prdata <= paddr[0] ? {16'h0000, rdSel[15:8], rdSel[15:8]} : {16'h0000, rdSel};
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~anyHit;

    // ****************************************
    // clock enables
    // ****************************************
    // the same bit drives both speed domains so they can never disagree
    assign hsEnGenTimer   = ~gateTimers[7:0];
    assign lsEnGenTimer   = ~gateTimers[7:0];
    assign hsEnFuncTimer  = ~gateFtimI2c[7:0];
    assign lsEnFuncTimer  = ~gateFtimI2c[7:0];
    assign hsEnI2cUnit0   = ~gateFtimI2c[`PCG_BIT_I2C_UNIT_0];
    assign lsEnI2cUnit0   = ~gateFtimI2c[`PCG_BIT_I2C_UNIT_0];
    assign hsEnI2cMaster  = ~{gateFtimI2c[`PCG_BIT_I2C_MASTER_1],
                              gateFtimI2c[`PCG_BIT_I2C_MASTER_0]};
    assign lsEnI2cMaster  = hsEnI2cMaster;
    assign hsEnSerialUnit = ~gateSerMisc[5:0];
    assign lsEnSerialUnit = ~gateSerMisc[5:0];
    assign hsEnDmaEngine  = ~gateSerMisc[`PCG_BIT_DMA_ENGINE];
    assign lsEnDmaEngine  = hsEnDmaEngine;
    assign hsEnBuzzer     = ~gateSerMisc[`PCG_BIT_BUZZER];
    assign lsEnBuzzer     = hsEnBuzzer;
    assign hsEnMulDivUnit = ~gateSerMisc[`PCG_BIT_MUL_DIV_UNIT];
    assign lsEnMulDivUnit = hsEnMulDivUnit;
    assign hsEnCrcUnit    = ~gateSerMisc[`PCG_BIT_CRC_UNIT];
    assign lsEnCrcUnit    = hsEnCrcUnit;

    // ****************************************
    // reset holds
    // ****************************************
    // the ordering reset, ungate, release is left to software
    assign rstHoldTimers  = regFlat[63:48];
    assign rstHoldFtimI2c = regFlat[79:64];
    assign rstHoldSerMisc = regFlat[95:80];

endmodule // pcg_gating_bank

// *** pcg_bank_props.sv ***
`timescale 1ns/10ps
`include "pcg_defs.vh"

// ****
// bank checker
// ****
module pcg_bank_props (
    // clock, reset, apb
    input wire        clk, srst, psel, penable, pwrite, pready, pslverr,
    input wire [15:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire [3:0]  pstrb,
    // clock enables and reset holds
    input wire [7:0]  hsEnGenTimer, hsEnFuncTimer, lsEnGenTimer, lsEnFuncTimer,
    input wire        hsEnI2cUnit0, hsEnDmaEngine, hsEnBuzzer, hsEnMulDivUnit, hsEnCrcUnit,
    input wire        lsEnI2cUnit0, lsEnDmaEngine, lsEnBuzzer, lsEnMulDivUnit, lsEnCrcUnit,
    input wire [1:0]  hsEnI2cMaster, lsEnI2cMaster,
    input wire [5:0]  hsEnSerialUnit, lsEnSerialUnit,
    input wire [15:0] rstHoldTimers, rstHoldFtimI2c, rstHoldSerMisc
);
    // both clock trees flattened so one compare covers every peripheral
    wire [28:0] hsAll = {hsEnGenTimer, hsEnFuncTimer, hsEnI2cUnit0, hsEnI2cMaster, hsEnSerialUnit,
                         hsEnDmaEngine, hsEnBuzzer, hsEnMulDivUnit, hsEnCrcUnit};
    wire [28:0] lsAll = {lsEnGenTimer, lsEnFuncTimer, lsEnI2cUnit0, lsEnI2cMaster, lsEnSerialUnit,
                         lsEnDmaEngine, lsEnBuzzer, lsEnMulDivUnit, lsEnCrcUnit};
    wire        wr = psel && penable && pwrite;
    // word slots 3 and 7 of the block are empty
    wire        mapped = paddr[15:4] == 12'hF07 && paddr[2:1] != 2'h3;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    zero_wait_a: assert property (psel && penable |-> pready) else $error("no ready in access");
    clock_pair_a: assert property (hsAll == lsAll) else $error("fast and slow enables differ");
    reset_run_a: assert property (disable iff (1'b0) srst |=> hsAll == 29'h1FFFFFFF && rstHoldTimers == 16'h0000)
        else $error("clocks not running after reset");
    unused_zero_a: assert property ((rstHoldTimers & ~`PCG_MASK_TIMERS) == 16'h0000
        && (rstHoldFtimI2c & ~`PCG_MASK_FTIM_I2C) == 16'h0000 && (rstHoldSerMisc & ~`PCG_MASK_SER_MISC) == 16'h0000)
        else $error("unused hold bit set");
    timer_gate_a: assert property (wr && paddr == 16'hF070 && pstrb[0] |=> hsEnGenTimer == ~$past(pwdata[7:0]))
        else $error("timer enables wrong");
    ftimer_gate_a: assert property (wr && paddr == 16'hF072 && pstrb[0] |=> hsEnFuncTimer == ~$past(pwdata[7:0]))
        else $error("functional timer enables wrong");
    i2c_gate_a: assert property (wr && paddr == 16'hF072 && pstrb[1] |=>
        {hsEnI2cUnit0, hsEnI2cMaster} == ~{$past(pwdata[12]), $past(pwdata[9:8])}) else $error("i2c enables wrong");
    serial_gate_a: assert property (wr && paddr == 16'hF074 && pstrb[0] |=> hsEnSerialUnit == ~$past(pwdata[5:0]))
        else $error("serial enables wrong");
    misc_gate_a: assert property (wr && paddr == 16'hF074 && pstrb[1] |=>
        {hsEnDmaEngine, hsEnBuzzer, hsEnMulDivUnit, hsEnCrcUnit} == ~{$past(pwdata[15:13]), $past(pwdata[11])})
        else $error("misc enables wrong");
    unmapped_err_a: assert property (psel && penable |-> pslverr == !mapped) else $error("error flag wrong");
    read_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");

    cover property (wr && pstrb == 4'h3);
    cover property (wr && paddr[0]);
    cover property (psel && penable && pslverr);
endmodule // pcg_bank_props

bind pcg_gating_bank pcg_bank_props i_props (.*);

// *** testbench.sv ***
`timescale 1ns/10ps

module testbench;
    // ****
    // stimulus and design outputs
    // ****
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, rdata;
    logic [3:0]  pstrb = 4'h0;
    int          err_total = 0, n_compared = 0, cyc = 0;
    wire         pready, pslverr;
    wire  [31:0] prdata;
    wire  [7:0]  hsEnGenTimer, hsEnFuncTimer, lsEnGenTimer, lsEnFuncTimer;
    wire  [5:0]  hsEnSerialUnit, lsEnSerialUnit;
    wire  [1:0]  hsEnI2cMaster, lsEnI2cMaster;
    wire         hsEnI2cUnit0, hsEnDmaEngine, hsEnBuzzer, hsEnMulDivUnit, hsEnCrcUnit;
    wire         lsEnI2cUnit0, lsEnDmaEngine, lsEnBuzzer, lsEnMulDivUnit, lsEnCrcUnit;
    wire  [15:0] rstHoldTimers, rstHoldFtimI2c, rstHoldSerMisc;
    wire  [28:0] hsAll = {hsEnGenTimer, hsEnFuncTimer, hsEnI2cUnit0, hsEnI2cMaster, hsEnSerialUnit,
                          hsEnDmaEngine, hsEnBuzzer, hsEnMulDivUnit, hsEnCrcUnit};
    wire  [28:0] lsAll = {lsEnGenTimer, lsEnFuncTimer, lsEnI2cUnit0, lsEnI2cMaster, lsEnSerialUnit,
                          lsEnDmaEngine, lsEnBuzzer, lsEnMulDivUnit, lsEnCrcUnit};
    // rows: write address, data, strobes, readback at the same address
    logic [15:0] rAdr [10] = '{16'hF070, 16'hF070, 16'hF072, 16'hF073, 16'hF074, 16'hF075, 16'hF078, 16'hF07A,
                               16'hF07C, 16'hF076};
    logic [15:0] rDat [10] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h0200, 16'hFFFF, 16'h0004, 16'hFFFF, 16'hFFFF,
                               16'hFFFF, 16'hFFFF};
    logic [3:0]  rStb [10] = '{4'h3, 4'h1, 4'h3, 4'h2, 4'h3, 4'h1, 4'h3, 4'h3, 4'h3, 4'h3};
    logic [15:0] rExp [10] = '{16'h00FF, 16'h0000, 16'h13FF, 16'h0202, 16'hE83F, 16'h0000, 16'h00FF, 16'h13FF,
                               16'hE83F, 16'h0000};

    pcg_gating_bank i_dut (.*);

    always #20 clk = ~clk;

    // ****
    // helpers
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; waits for ready under a bound so a dead slave cannot hang us
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            err_total++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task print_verdict;
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard, far above the roughly 100 cycles of the run
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            err_total++;
            print_verdict;
        end
    end

    // ****
    // main sequence
    // ****
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk({3'h0, hsAll & lsAll}, 32'h1FFFFFFF);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, 16'hF070 + 16'(2 * i), 32'h0, 4'h0, rdata, err);
            chk(rdata, 32'h0);
        end
        foreach (rAdr[i])
        begin
            apb(1'b1, rAdr[i], {rDat[i], rDat[i]}, rStb[i], rdata, err);
            apb(1'b0, rAdr[i], 32'h0, 4'h0, rdata, err);
            chk(rdata, {16'h0, rExp[i]});
            chk({31'h0, err}, {31'h0, rAdr[i] == 16'hF076});
        end
        // gated bits show as stopped clocks on both trees
        chk({3'h0, hsAll}, {3'h0, 8'hFF, 8'h00, 1'b1, 2'b01, 6'h00, 4'hF});
        chk({3'h0, lsAll}, {3'h0, 8'hFF, 8'h00, 1'b1, 2'b01, 6'h00, 4'hF});
        chk({rstHoldTimers, rstHoldFtimI2c}, 32'h00FF13FF);
        chk({16'h0, rstHoldSerMisc}, 32'h0000E83F);
        // mul/div stopped by a high byte write of bit 13 at 0xF074
        apb(1'b1, 16'hF074, 32'h00002000, 4'h2, rdata, err);
        @(negedge clk);
        chk({30'h0, hsEnMulDivUnit, lsEnMulDivUnit}, 32'h0);
        // restart a stopped timer: hold in reset, ungate, then release
        apb(1'b1, 16'hF070, 32'h00000001, 4'h1, rdata, err);
        apb(1'b1, 16'hF078, 32'h00000001, 4'h1, rdata, err);
        apb(1'b1, 16'hF070, 32'h00000000, 4'h1, rdata, err);
        @(negedge clk);
        chk({16'h0, hsEnGenTimer, rstHoldTimers[7:0]}, 32'h0000FF01);
        apb(1'b1, 16'hF078, 32'h00000000, 4'h1, rdata, err);
        @(negedge clk);
        chk({16'h0, rstHoldTimers}, 32'h0);
        // second reset in mid-run must restore every running clock
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk({3'h0, hsAll & lsAll}, 32'h1FFFFFFF);
        chk({rstHoldTimers, rstHoldFtimI2c | rstHoldSerMisc}, 32'h0);
        print_verdict;
    end
endmodule // testbench
